// >>> core/clkdly_pkg.sv
// Purpose: shared constants and types for the clock delay ramp and alarms
// Assumes: one sampling clock, byte-wide register port
// Notes: offsets are byte addresses on the plain register port
`default_nettype none
package clkdly_pkg;

  // ----------------------------------------
  // Register port widths and offsets
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] OFS_COARSE = 12'h2B6;
  localparam logic [11:0] OFS_RAMP_CTRL = 12'h2B8;
  localparam logic [11:0] OFS_SUMMARY = 12'h2C0;
  localparam logic [11:0] OFS_FLAGS = 12'h2C1;
  localparam logic [11:0] OFS_MASK = 12'h2C2;
  localparam logic [11:0] OFS_PIN_SEL = 12'h2C8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_STEP_EN = 0;
  localparam int BIT_STEP_RATE = 1;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_DIVMIS = 0;
  localparam int BIT_SUMMARY = 0;
  localparam int BIT_PIN_SEL = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_RAMP_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h05;
  localparam logic [7:0] RST_MASK = 8'h05;
  localparam logic [7:0] RST_COARSE = 8'h00;
  localparam logic [7:0] RST_PIN_SEL = 8'h00;

  // ----------------------------------------
  // Timing, in sampling-clock cycles; ramp step sizes in codes
  // ----------------------------------------
  localparam int RAMP_PERIOD_CYC = 256;
  localparam int NORAMP_LIMIT_CYC = 1024;
  localparam logic [7:0] STEP_SLOW = 8'h01;
  localparam logic [7:0] STEP_FAST = 8'h04;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic {ST_IDLE, ST_RAMP} ramp_state_t;

  typedef struct packed {
    logic flag;
  } flag_st_t;

endpackage
`default_nettype wire

// >>> core/sticky_flag.sv
// Purpose: one sticky alert flag, set by an event, cleared by write-one
// Assumes: event and clear come from logic on mclk
// Notes: reset and soft reset both leave the flag set
`default_nettype none
module sticky_flag
  import clkdly_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk, // Sampling clock
  input wire logic rst, // Async reset, high
  input wire logic soft_reset, // Soft reset pulse
  input wire logic set_evt, // Event that raises the flag
  input wire logic clr, // Write-one-to-clear strobe
  output logic flag // Sticky flag level
);
  flag_st_t st;
  flag_st_t nx;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Set beats clear so no event is lost
  always_comb begin
    nx = st;
    if (clr) begin
      nx.flag = 1'b0;
    end
    if (set_evt || soft_reset) begin
      nx.flag = 1'b1;
    end
  end

  // Register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.flag <= RST_VAL;
    end else begin
      st <= nx;
    end
  end

  assign flag = st.flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
    set_evt |=> flag)
    else $error("flag lost an event");
  AST_HOLD_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (flag && !clr) |=> flag)
    else $error("flag dropped without clear");
  AST_SOFT_SET: assert property (@(posedge mclk) disable iff (rst)
    soft_reset |=> flag)
    else $error("soft reset left flag low");
  AST_CLEAR_WORKS: assert property (@(posedge mclk) disable iff (rst)
    (clr && !set_evt && !soft_reset) |=> !flag)
    else $error("flag not cleared by write");
endmodule
`default_nettype wire

// >>> core/clock_delay_ramp_and_alarms.sv
// Purpose: coarse clock delay apply/ramp control and alert flag logic
// Assumes: all inputs are on mclk; register read data one cycle later
// Notes: delay value registers beyond the coarse byte live elsewhere
`default_nettype none
module clock_delay_ramp_and_alarms
  import clkdly_pkg::*;
#(
  parameter int DIV_W = 4,
  parameter int PRE_W = 8
) (
  input wire logic mclk, // Sampling clock
  input wire logic rst, // Async reset, high
  input wire logic soft_reset, // Soft reset pulse
  input wire clkdly_pkg::reg_req_t req, // Register request
  output logic [clkdly_pkg::DATA_W-1:0] rd_data, // Read data
  input wire logic sysref_realign, // Realign event pulse
  input wire logic [DIV_W-1:0] div_phase_a, // Channel A divider
  input wire logic [DIV_W-1:0] div_phase_b, // Channel B divider
  input wire logic cal_done, // Calibration status
  output logic cal_status_pin, // Status pin drive
  output logic [7:0] applied_delay, // Coarse delay in use
  output logic ramp_busy // Ramp in progress
);
  import clkdly_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ramp_state_t fsm;
    logic step_en;
    logic step_rate;
    logic pin_sel;
    logic mask_realign;
    logic mask_divmis;
    logic [7:0] target;
    logic [7:0] applied;
    logic [PRE_W-1:0] prescale;
    logic [7:0] rd_data;
    logic pin;
    logic busy;
  } core_st_t;

  localparam logic [PRE_W-1:0] PRE_LAST =
    PRE_W'(RAMP_PERIOD_CYC - 1);

  core_st_t st;
  core_st_t nx;
  logic flag_realign;
  logic flag_divmis;
  logic clr_realign;
  logic clr_divmis;
  logic summary;
  logic [7:0] step_val;

  // ----------------------------------------
  // Alert flags
  // ----------------------------------------
  // Write-one strobes for each flag
  assign clr_realign = req.wr && (req.addr == OFS_FLAGS)
    && req.wdata[BIT_REALIGN];
  assign clr_divmis = req.wr && (req.addr == OFS_FLAGS)
    && req.wdata[BIT_DIVMIS];

  sticky_flag #(
    .RST_VAL(RST_FLAGS[BIT_REALIGN])
  ) u_realign (
    .mclk(mclk),
    .rst(rst),
    .soft_reset(soft_reset),
    .set_evt(sysref_realign),
    .clr(clr_realign),
    .flag(flag_realign)
  );

  // Mismatch is a level: it re-sets each cycle it lasts
  sticky_flag #(
    .RST_VAL(RST_FLAGS[BIT_DIVMIS])
  ) u_divmis (
    .mclk(mclk),
    .rst(rst),
    .soft_reset(soft_reset),
    .set_evt(div_phase_a != div_phase_b),
    .clr(clr_divmis),
    .flag(flag_divmis)
  );

  // Summary of unmasked flags
  assign summary = (flag_realign && !st.mask_realign)
    || (flag_divmis && !st.mask_divmis);

  // ----------------------------------------
  // Ramp step
  // ----------------------------------------
  // Clamp the step so the last one never passes the target
  function automatic logic [7:0] step_toward(
    input logic [7:0] cur,
    input logic [7:0] tgt,
    input logic fast
  );
    logic [7:0] sz;
    logic [7:0] gap;
    sz = fast ? STEP_FAST : STEP_SLOW;
    if (tgt > cur) begin
      gap = tgt - cur;
      step_toward = cur + ((gap < sz) ? gap : sz);
    end else begin
      gap = cur - tgt;
      step_toward = cur - ((gap < sz) ? gap : sz);
    end
  endfunction

  assign step_val = step_toward(st.applied, st.target, st.step_rate);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    nx.rd_data = '0;
    // Ramp off: applied follows target on the next edge
    if (st.fsm == ST_IDLE && !st.step_en) begin
      nx.applied = st.target;
    end
    // Ramp on: one step at the end of each period
    if (st.fsm == ST_RAMP) begin
      nx.prescale = st.prescale + 1'b1;
      if (st.prescale == PRE_LAST) begin
        nx.applied = step_val;
        if (step_val == st.target) begin
          nx.fsm = ST_IDLE;
        end
      end
      if (!st.step_en) begin
        nx.fsm = ST_IDLE;
      end
    end
    // Register writes; summary offset has no write effect
    if (req.wr) begin
      case (req.addr)
        OFS_COARSE: begin
          nx.target = req.wdata;
          if (st.step_en) begin
            nx.fsm = ST_RAMP;
            nx.prescale = '0;
          end
        end
        OFS_RAMP_CTRL: begin
          nx.step_en = req.wdata[BIT_STEP_EN];
          nx.step_rate = req.wdata[BIT_STEP_RATE];
        end
        OFS_MASK: begin
          nx.mask_realign = req.wdata[BIT_REALIGN];
          nx.mask_divmis = req.wdata[BIT_DIVMIS];
        end
        OFS_PIN_SEL: begin
          nx.pin_sel = req.wdata[BIT_PIN_SEL];
        end
        default: begin
          nx.pin_sel = nx.pin_sel;
        end
      endcase
    end
    // Register reads; unmapped reads return zero
    if (req.rd) begin
      case (req.addr)
        OFS_COARSE: begin
          nx.rd_data = st.target;
        end
        OFS_RAMP_CTRL: begin
          nx.rd_data[BIT_STEP_EN] = st.step_en;
          nx.rd_data[BIT_STEP_RATE] = st.step_rate;
        end
        OFS_SUMMARY: begin
          nx.rd_data[BIT_SUMMARY] = summary;
        end
        OFS_FLAGS: begin
          nx.rd_data[BIT_REALIGN] = flag_realign;
          nx.rd_data[BIT_DIVMIS] = flag_divmis;
        end
        OFS_MASK: begin
          nx.rd_data[BIT_REALIGN] = st.mask_realign;
          nx.rd_data[BIT_DIVMIS] = st.mask_divmis;
        end
        OFS_PIN_SEL: begin
          nx.rd_data[BIT_PIN_SEL] = st.pin_sel;
        end
        default: begin
          nx.rd_data = '0;
        end
      endcase
    end
    // Status pin: alarm summary or calibration status
    nx.pin = st.pin_sel ? summary : cal_done;
    nx.busy = (nx.fsm == ST_RAMP);
  end

  // ----------------------------------------
  // Register
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.fsm <= ST_IDLE;
      st.step_en <= RST_RAMP_CTRL[BIT_STEP_EN];
      st.step_rate <= RST_RAMP_CTRL[BIT_STEP_RATE];
      st.pin_sel <= RST_PIN_SEL[BIT_PIN_SEL];
      st.mask_realign <= RST_MASK[BIT_REALIGN];
      st.mask_divmis <= RST_MASK[BIT_DIVMIS];
      st.target <= RST_COARSE;
      st.applied <= RST_COARSE;
      st.prescale <= '0;
      st.rd_data <= '0;
      st.pin <= 1'b0;
      st.busy <= 1'b0;
    end else begin
      st <= nx;
    end
  end

  assign rd_data = st.rd_data;
  assign cal_status_pin = st.pin;
  assign applied_delay = st.applied;
  assign ramp_busy = st.busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_coarse_wr_noramp;
    req.wr && req.addr == OFS_COARSE && !st.step_en
      && st.fsm == ST_IDLE;
  endsequence

  sequence s_ramp_start;
    req.wr && req.addr == OFS_COARSE && st.step_en;
  endsequence

  sequence s_step_edge;
    st.fsm == ST_RAMP && st.prescale == PRE_LAST && !req.wr;
  endsequence

  AST_NORAMP_APPLY: assert property (
    s_coarse_wr_noramp ##1 !req.wr[*1] |=> applied_delay == $past(st.target))
    else $error("unramped delay not applied");

  AST_RAMP_BUSY: assert property (
    s_ramp_start |=> ramp_busy)
    else $error("ramp did not start");

  AST_RAMP_QUIET: assert property (
    (st.fsm == ST_RAMP && st.prescale != PRE_LAST)
      |=> $stable(applied_delay))
    else $error("delay moved between steps");

  AST_SLOW_STEP: assert property (
    (s_step_edge and !st.step_rate && st.target != st.applied)
      |=> (applied_delay == $past(st.applied) + 8'h01)
        || (applied_delay == $past(st.applied) - 8'h01))
    else $error("slow step size wrong");

  AST_FAST_STEP: assert property (
    (s_step_edge and st.step_rate && st.target > st.applied
      && st.target - st.applied > 8'h04)
      |=> applied_delay == $past(st.applied) + 8'h04)
    else $error("fast step size wrong");

  AST_LAND_EXACT: assert property (
    (s_step_edge and st.step_rate && st.target > st.applied
      && st.target - st.applied <= 8'h04)
      |=> applied_delay == $past(st.target) && !ramp_busy)
    else $error("last step missed target");

  AST_CTRL_RESV: assert property (
    (req.rd && req.addr == OFS_RAMP_CTRL) |=> rd_data[7:2] == 6'h00)
    else $error("reserved control bits not zero");

  AST_SUMMARY_RD: assert property (
    (req.rd && req.addr == OFS_SUMMARY)
      |=> rd_data[BIT_SUMMARY] == $past(summary))
    else $error("summary bit wrong");

  AST_PIN_ROUTE: assert property (
    st.pin_sel |=> cal_status_pin == $past(summary))
    else $error("status pin not routed");

  AST_MASK_GATE: assert property (
    (st.mask_realign && st.mask_divmis) |-> !summary)
    else $error("masked flag reached summary");

  // ----------------------------------------
  // Top-level flag, pin and hold checks
  // ----------------------------------------
  // Software view of the flags and the write-ignored summary
  sequence s_flag_rd;
    req.rd && req.addr == OFS_FLAGS;
  endsequence

  sequence s_summary_wr;
    req.wr && req.addr == OFS_SUMMARY;
  endsequence

  AST_FLAG_RD: assert property (
    s_flag_rd |=> rd_data[BIT_REALIGN] == $past(flag_realign)
      && rd_data[BIT_DIVMIS] == $past(flag_divmis))
    else $error("flag read back wrong");

  AST_SUMMARY_RO: assert property (
    s_summary_wr |=> $stable({st.target, st.step_en, st.step_rate,
      st.mask_realign, st.mask_divmis, st.pin_sel}))
    else $error("summary write changed state");

  AST_REALIGN_SET: assert property (
    sysref_realign |=> flag_realign)
    else $error("realign event not flagged");

  AST_DIVMIS_SET: assert property (
    (div_phase_a != div_phase_b) |=> flag_divmis)
    else $error("divider mismatch not flagged");

  AST_PIN_CAL: assert property (
    !st.pin_sel |=> cal_status_pin == $past(cal_done))
    else $error("status pin not on calibration status");

  // Unramped delay tracks the target one edge later, far inside the limit
  AST_NORAMP_HOLD: assert property (
    (st.fsm == ST_IDLE && !st.step_en) |=> applied_delay == $past(st.target))
    else $error("unramped delay not following target");

  // Enabled but idle: only a ramp may move the delay
  AST_RAMP_HOLD: assert property (
    (st.fsm == ST_IDLE && st.step_en) |=> $stable(applied_delay))
    else $error("delay moved without a ramp");
endmodule
`default_nettype wire

// >>> test/test_clock_delay_ramp_and_alarms.sv
// Purpose: self-checking bench for the coarse delay ramp and alert flags
// Assumes: register port with read data one cycle after the read strobe
// Notes: step timing measured as cycles between changes of applied_delay
`default_nettype none
module test_clock_delay_ramp_and_alarms;
  timeunit 1ns;
  timeprecision 1ps;
  import clkdly_pkg::*;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk, rst, soft_reset, sysref_realign, cal_done;
  clkdly_pkg::reg_req_t req;
  logic [3:0] div_phase_a, div_phase_b;
  logic [7:0] rd_data, applied_delay, rdv;
  logic cal_status_pin, ramp_busy;
  int bad_count, checks, n;

  clock_delay_ramp_and_alarms #(.DIV_W(4), .PRE_W(8)) dut_u (
    .mclk(mclk), .rst(rst), .soft_reset(soft_reset), .req(req), .rd_data(rd_data),
    .sysref_realign(sysref_realign), .div_phase_a(div_phase_a),
    .div_phase_b(div_phase_b), .cal_done(cal_done), .cal_status_pin(cal_status_pin),
    .applied_delay(applied_delay), .ramp_busy(ramp_busy));

  // 25 MHz sampling clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    rdv = rd_data;
  endtask

  // Cycles until applied_delay moves; limit keeps a stuck ramp from hanging
  task automatic wait_change(input int limit);
    logic [7:0] old;
    old = applied_delay;
    n = 0;
    while (applied_delay === old && n < limit) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  task automatic pulse(input int which);
    @(posedge mclk);
    if (which == 0) sysref_realign <= 1'b1;
    else if (which == 1) div_phase_b <= 4'h2;
    else soft_reset <= 1'b1;
    @(posedge mclk);
    sysref_realign <= 1'b0;
    div_phase_b <= 4'h1;
    soft_reset <= 1'b0;
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Register table: address, write data, value read back
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  row_t rows[10] = '{
    '{12'h2B8, 8'hFF, 8'h03}, // Reserved bits not kept
    '{12'h2B8, 8'h00, 8'h00},
    '{12'h2C2, 8'h00, 8'h00}, // Unmask both
    '{12'h2C0, 8'h00, 8'h01}, // Write ignored, flags unmasked
    '{12'h2C1, 8'h00, 8'h05}, // Zero keeps flags
    '{12'h2C1, 8'h01, 8'h04},
    '{12'h2C0, 8'hFF, 8'h01},
    '{12'h2C1, 8'h04, 8'h00},
    '{12'h2C0, 8'h00, 8'h00}, // Nothing left set
    '{12'h2C3, 8'hFF, 8'h00}  // Unmapped place
  };

  // Watchdog: whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    checks = 0;
    rst = 1'b1;
    soft_reset = 1'b0;
    sysref_realign = 1'b0;
    cal_done = 1'b0;
    req = '0;
    div_phase_a = 4'h1;
    div_phase_b = 4'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // Reset values
    rd_reg(12'h2B8); cmp8(rdv, 8'h00);
    rd_reg(12'h2C1); cmp8(rdv, 8'h05);
    rd_reg(12'h2C2); cmp8(rdv, 8'h05);
    rd_reg(12'h2C0); cmp8(rdv, 8'h00); // Flags set but masked
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      cmp8(rdv, rows[i].e);
    end
    // Events set flags; summary routed to the status pin
    pulse(0);
    rd_reg(12'h2C1); cmp8(rdv, 8'h04);
    wr_reg(12'h2C8, 8'h01);
    repeat (3) @(posedge mclk);
    #1 cmp8({7'h0, cal_status_pin}, 8'h01);
    wr_reg(12'h2C2, 8'h04);
    repeat (3) @(posedge mclk);
    #1 cmp8({7'h0, cal_status_pin}, 8'h00); // Masked flag drops pin
    pulse(1);
    rd_reg(12'h2C1); cmp8(rdv, 8'h05);
    rd_reg(12'h2C0); cmp8(rdv, 8'h01);
    // Clear in the same cycle as a realign event: flag must stay set
    @(posedge mclk);
    sysref_realign <= 1'b1;
    wr_reg(12'h2C1, 8'h05);
    sysref_realign <= 1'b0;
    rd_reg(12'h2C1); cmp8(rdv, 8'h04);
    wr_reg(12'h2C1, 8'h04);
    pulse(2);
    rd_reg(12'h2C1); cmp8(rdv, 8'h05); // Soft reset sets all
    rd_reg(12'h2C2); cmp8(rdv, 8'h04); // Mask untouched by soft reset
    // Summary is high here, so a low pin proves the switch to calibration status
    wr_reg(12'h2C8, 8'h00);
    repeat (3) @(posedge mclk);
    #1 cmp8({7'h0, cal_status_pin}, 8'h00); // Pin back on calibration status
    @(posedge mclk);
    cal_done <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 cmp8({7'h0, cal_status_pin}, 8'h01); // Pin follows calibration status
    // Ramp off: four-code move lands within the limit
    wr_reg(12'h2B6, 8'h04); // Small step keeps software side legal
    wait_change(NORAMP_LIMIT_CYC);
    cmp8(applied_delay, 8'h04);
    cmp8({7'h0, ramp_busy}, 8'h00);
    // Fast rate: 0x04 -> 0x0A is one step of four and a short last step
    wr_reg(12'h2B8, 8'h03);
    wr_reg(12'h2B6, 8'h0A);
    wait_change(300);
    cmp8({7'h0, n >= 250 && n <= 260}, 8'h01);
    cmp8(applied_delay, 8'h08);
    cmp8({7'h0, ramp_busy}, 8'h01);
    wait_change(300);
    cmp8(n[7:0], 8'h00); // Exactly 256 cycles apart
    cmp8(applied_delay, 8'h0A); // No overshoot
    cmp8({7'h0, ramp_busy}, 8'h00);
    // Slow rate downwards: one code per period
    wr_reg(12'h2B8, 8'h01);
    wr_reg(12'h2B6, 8'h08);
    wait_change(300);
    cmp8(applied_delay, 8'h09);
    wait_change(300);
    cmp8(n[7:0], 8'h00);
    cmp8(applied_delay, 8'h08);
    repeat (300) @(posedge mclk);
    #1 cmp8(applied_delay, 8'h08); // Holds at target
    // Second reset in mid-run: clear flags and unmask first so the reset shows
    wr_reg(12'h2C1, 8'h05);
    wr_reg(12'h2C2, 8'h00);
    rd_reg(12'h2C1); cmp8(rdv, 8'h00);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1 cmp8(applied_delay, 8'h00);
    rd_reg(12'h2C1); cmp8(rdv, 8'h05);
    rd_reg(12'h2C2); cmp8(rdv, 8'h05);
    rd_reg(12'h2B8); cmp8(rdv, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
